// ---- verilog/cab_pkg.sv ----
// shared constants and types for the alu and branch datapath
package cab_pkg;
   // status flag bit positions
   localparam int FLG_C = 0;
   localparam int FLG_Z = 1;
   localparam int FLG_N = 2;
   localparam int FLG_V = 3;
   localparam int FLG_S = 4;
   localparam int FLG_H = 5;
   localparam int FLG_I = 7;
   // flag update masks
   localparam logic [7:0] MSK_NONE = 8'h00;
   localparam logic [7:0] MSK_ARITH = 8'h3f;
   localparam logic [7:0] MSK_LOGIC = 8'h1e;
   localparam logic [7:0] MSK_CZNVS = 8'h1f;
   localparam logic [7:0] MSK_PROD = 8'h03;
   localparam logic [7:0] FLAGS_RST = 8'h00;
   // register bus map
   localparam logic [5:0] ADR_GPR_LAST = 6'h1f;
   localparam logic [5:0] ADR_FLAGS = 6'h20;
   localparam logic [5:0] ADR_PC_LO = 6'h21;
   localparam logic [5:0] ADR_PC_HI = 6'h22;
   localparam logic [5:0] ADR_DEPTH = 6'h23;
   // fixed operands and register indices
   localparam logic [7:0] ALL_ONES = 8'hff;
   localparam logic [7:0] ALL_ZERO = 8'h00;
   localparam logic [7:0] ONE = 8'h01;
   localparam logic [4:0] IDX_ZLO = 5'h1e;
   localparam logic [4:0] IDX_ZHI = 5'h1f;
   localparam logic [4:0] IDX_PLO = 5'h00;
   localparam logic [4:0] IDX_PHI = 5'h01;
   // instruction cycle counts and skip distances
   localparam logic [2:0] CYC_1 = 3'h1;
   localparam logic [2:0] CYC_2 = 3'h2;
   localparam logic [2:0] CYC_3 = 3'h3;
   localparam logic [2:0] CYC_4 = 3'h4;
   localparam logic [1:0] SKIP_SHORT = 2'h2;
   localparam logic [1:0] SKIP_LONG = 2'h3;
   // decoded operations
   typedef enum logic [5:0] {
      op_add, op_adc, op_word_immediate_increase, op_sub,
      op_difference_immediate, op_difference_with_borrow,
      op_difference_immediate_borrow, op_word_immediate_decrease,
      op_and, op_conjunction_immediate, op_or, op_disjunction_immediate,
      op_exclusive_disjunction, op_bit_inversion, op_twos_complement_op,
      op_bit_set_mask, op_bit_clear_mask, op_inc, op_dec,
      op_zero_sign_test, op_register_zeroing, op_register_all_ones,
      op_product_unsigned, op_product_signed, op_product_mixed_sign,
      op_fraction_product_unsigned, op_fraction_product_signed,
      op_fraction_product_mixed, op_relative_branch_always,
      op_pointer_branch, op_relative_subroutine_entry,
      op_pointer_subroutine_entry, op_subroutine_exit, op_interrupt_exit,
      op_equal_skip, op_flag_only_difference,
      op_flag_only_difference_borrow, op_flag_only_difference_immediate
   } cab_op_type;
endpackage

// ---- verilog/cab_alu_if.sv ----
// operand and result bundle between the datapath and its alu
`timescale 1ns/1ps
interface cab_alu_if;
   cab_pkg::cab_op_type op; // operation in flight
   logic [7:0] a; // destination operand
   logic [7:0] b; // source operand or constant
   logic [15:0] w; // register pair operand
   logic [7:0] fin; // current flags
   logic [15:0] res; // byte, pair or product result
   logic [7:0] fval; // new flag values
   logic [7:0] fmask; // flags to update
   modport core (output op, a, b, w, fin, input res, fval, fmask);
   modport unit (input op, a, b, w, fin, output res, fval, fmask);
endinterface

// ---- verilog/cab_alu.sv ----
// combinational alu: byte, word and product results with flags
`timescale 1ns/1ps
module cab_alu (
   // operands in, results out
   cab_alu_if.unit alu
);
   logic cin; // carry or borrow in
   logic [8:0] sum; // byte sum
   logic [8:0] dif; // byte difference
   logic [16:0] wsum; // pair plus constant
   logic [16:0] wdif; // pair minus constant
   logic [15:0] p_uu; // unsigned product
   logic [15:0] p_ss; // signed product
   logic [15:0] p_su; // mixed sign product
   logic [15:0] p; // chosen product
   logic [15:0] r; // result
   logic c, h, v, n, z, wide; // working flags
   logic [7:0] m; // update mask

   // shared adders and multipliers
   always_comb begin
      case (alu.op)
         cab_pkg::op_adc, cab_pkg::op_difference_with_borrow,
         cab_pkg::op_difference_immediate_borrow,
         cab_pkg::op_flag_only_difference_borrow: cin = alu.fin[cab_pkg::FLG_C];
         default: cin = 1'b0;
      endcase
      sum = {1'b0, alu.a} + {1'b0, alu.b} + {8'h00, cin};
      dif = {1'b0, alu.a} - {1'b0, alu.b} - {8'h00, cin};
      wsum = {1'b0, alu.w} + {9'h000, alu.b};
      wdif = {1'b0, alu.w} - {9'h000, alu.b};
      p_uu = alu.a * alu.b;
      p_ss = 16'($signed(alu.a) * $signed(alu.b));
      p_su = 16'($signed(alu.a) * $signed({1'b0, alu.b}));
   end

   // result and flag selection
   always_comb begin
      r = 16'h0000;
      c = 1'b0;
      h = 1'b0;
      v = 1'b0;
      wide = 1'b0;
      p = p_uu;
      m = cab_pkg::MSK_NONE;
      case (alu.op)
         cab_pkg::op_add, cab_pkg::op_adc, cab_pkg::op_inc: begin
            r = {8'h00, sum[7:0]};
            c = sum[8];
            h = (alu.a[3] & alu.b[3]) | (alu.b[3] & ~sum[3]) | (~sum[3] & alu.a[3]);
            v = (alu.a[7] & alu.b[7] & ~sum[7]) | (~alu.a[7] & ~alu.b[7] & sum[7]);
            m = (alu.op == cab_pkg::op_inc) ? cab_pkg::MSK_LOGIC : cab_pkg::MSK_ARITH;
         end
         cab_pkg::op_sub, cab_pkg::op_difference_immediate, cab_pkg::op_difference_with_borrow,
         cab_pkg::op_difference_immediate_borrow, cab_pkg::op_twos_complement_op,
         cab_pkg::op_dec, cab_pkg::op_flag_only_difference,
         cab_pkg::op_flag_only_difference_borrow,
         cab_pkg::op_flag_only_difference_immediate: begin
            r = {8'h00, dif[7:0]};
            c = dif[8];
            h = (~alu.a[3] & alu.b[3]) | (alu.b[3] & dif[3]) | (dif[3] & ~alu.a[3]);
            v = (alu.a[7] & ~alu.b[7] & ~dif[7]) | (~alu.a[7] & alu.b[7] & dif[7]);
            m = (alu.op == cab_pkg::op_dec) ? cab_pkg::MSK_LOGIC : cab_pkg::MSK_ARITH;
         end
         cab_pkg::op_and, cab_pkg::op_conjunction_immediate, cab_pkg::op_zero_sign_test: begin
            r = {8'h00, alu.a & alu.b};
            m = cab_pkg::MSK_LOGIC;
         end
         cab_pkg::op_or, cab_pkg::op_disjunction_immediate, cab_pkg::op_bit_set_mask: begin
            r = {8'h00, alu.a | alu.b};
            m = cab_pkg::MSK_LOGIC;
         end
         cab_pkg::op_exclusive_disjunction, cab_pkg::op_register_zeroing: begin
            r = {8'h00, alu.a ^ alu.b};
            m = cab_pkg::MSK_LOGIC;
         end
         cab_pkg::op_bit_clear_mask: begin
            r = {8'h00, alu.a & (cab_pkg::ALL_ONES - alu.b)};
            m = cab_pkg::MSK_LOGIC;
         end
         cab_pkg::op_bit_inversion: begin
            r = {8'h00, cab_pkg::ALL_ONES - alu.a};
            c = 1'b1;
            m = cab_pkg::MSK_CZNVS;
         end
         cab_pkg::op_register_all_ones: r = {8'h00, cab_pkg::ALL_ONES};
         cab_pkg::op_word_immediate_increase: begin
            r = wsum[15:0];
            c = wsum[16];
            v = ~alu.w[15] & wsum[15];
            wide = 1'b1;
            m = cab_pkg::MSK_CZNVS;
         end
         cab_pkg::op_word_immediate_decrease: begin
            r = wdif[15:0];
            c = wdif[16];
            v = alu.w[15] & ~wdif[15];
            wide = 1'b1;
            m = cab_pkg::MSK_CZNVS;
         end
         cab_pkg::op_product_unsigned, cab_pkg::op_product_signed, cab_pkg::op_product_mixed_sign,
         cab_pkg::op_fraction_product_unsigned, cab_pkg::op_fraction_product_signed,
         cab_pkg::op_fraction_product_mixed: begin
            if (alu.op == cab_pkg::op_product_signed || alu.op == cab_pkg::op_fraction_product_signed) begin
               p = p_ss;
            end else if (alu.op == cab_pkg::op_product_mixed_sign ||
                         alu.op == cab_pkg::op_fraction_product_mixed) begin
               p = p_su;
            end
            c = p[15];
            if (alu.op == cab_pkg::op_fraction_product_unsigned || alu.op == cab_pkg::op_fraction_product_signed ||
                alu.op == cab_pkg::op_fraction_product_mixed) begin
               r = {p[14:0], 1'b0};
            end else begin
               r = p;
            end
            wide = 1'b1;
            m = cab_pkg::MSK_PROD;
         end
         // branches leave flags alone
         default: m = cab_pkg::MSK_NONE;
      endcase
      n = wide ? r[15] : r[7];
      z = wide ? (r == 16'h0000) : (r[7:0] == 8'h00);
      alu.res = r;
      alu.fmask = m;
      alu.fval = {alu.fin[7:6], h, n ^ v, v, n, z, c};
   end
endmodule

// ---- verilog/cab_datapath.sv ----
// datapath top: register file, flags, program counter and return stack
`timescale 1ns/1ps
module cab_datapath #(
   parameter int PC_W = 12, // program counter width, 9 to 16
   parameter int DEPTH = 16 // return stack entries
) (
   // clock and reset
   input logic clk,
   input logic rst,
   // decoded instruction from fetch
   input logic op_valid,
   input cab_pkg::cab_op_type op_code,
   input logic [4:0] rd_sel,
   input logic [4:0] rr_sel,
   input logic [7:0] imm_k,
   input logic [PC_W-1:0] rel_k,
   input logic skip_long,
   output logic op_ready,
   // core state seen outside
   output logic [PC_W-1:0] pc_out,
   output logic [7:0] flags_out,
   // register bus
   input logic [5:0] reg_addr,
   input logic [7:0] reg_wdata,
   input logic reg_wr,
   input logic reg_rd,
   output logic [7:0] reg_rdata
);
   localparam int SP_W = $clog2(DEPTH);

   // issue or hold while a long instruction finishes
   typedef enum logic [1:0] {
      st_idle = 2'b01,
      st_hold = 2'b10
   } cab_fsm_type;

   // every control register of the block
   typedef struct packed {
      cab_fsm_type fsm; // issue state
      logic [2:0] hold; // cycles still held
      logic [PC_W-1:0] pc; // program counter
      logic [SP_W-1:0] sp; // return stack fill
      logic [7:0] flags; // status flags
      logic [7:0] rdata; // bus read data
   } cab_state_type;

   cab_state_type st_ff; // registered state
   cab_state_type nxt_st; // next state

   logic [7:0] rf [32]; // general registers
   logic [PC_W-1:0] stk [DEPTH]; // return addresses

   logic take; // instruction accepted this cycle
   logic [4:0] rd_hi; // upper register of a pair
   logic [15:0] zw; // pointer pair
   logic [15:0] pc16; // pc widened for the bus
   logic [15:0] pcw; // pc with new high byte
   logic [PC_W-1:0] pc_next; // address after this one
   logic [SP_W-1:0] sp_top; // newest stack entry
   logic [7:0] fl_base; // flags after any bus write
   logic [2:0] cyc; // cycles of this instruction
   logic lo_en; // write low result byte
   logic hi_en; // write high result byte
   logic [4:0] lo_idx; // low byte target
   logic [4:0] hi_idx; // high byte target
   logic push; // store return address

   cab_alu_if ab ();

   // arithmetic and logic unit
   cab_alu u_alu (
      .alu(ab)
   );

   // fixed helper values
   assign take = op_valid && (st_ff.fsm == st_idle);
   assign rd_hi = 5'(rd_sel + 5'h01);
   assign zw = {rf[cab_pkg::IDX_ZHI], rf[cab_pkg::IDX_ZLO]};
   assign pc16 = 16'(st_ff.pc);
   assign pcw = {reg_wdata, pc16[7:0]};
   assign pc_next = st_ff.pc + 1'b1;
   assign sp_top = st_ff.sp - 1'b1;

   // outputs
   assign op_ready = (st_ff.fsm == st_idle);
   assign pc_out = st_ff.pc;
   assign flags_out = st_ff.flags;
   assign reg_rdata = st_ff.rdata;

   // operand steering into the alu
   always_comb begin
      ab.op = op_code;
      ab.a = rf[rd_sel];
      ab.b = rf[rr_sel];
      ab.w = {rf[rd_hi], rf[rd_sel]};
      ab.fin = st_ff.flags;
      case (op_code)
         // constant and same-register forms
         cab_pkg::op_difference_immediate, cab_pkg::op_difference_immediate_borrow,
         cab_pkg::op_conjunction_immediate, cab_pkg::op_disjunction_immediate,
         cab_pkg::op_bit_set_mask, cab_pkg::op_bit_clear_mask,
         cab_pkg::op_flag_only_difference_immediate: ab.b = imm_k;
         cab_pkg::op_word_immediate_increase, cab_pkg::op_word_immediate_decrease: begin
            ab.b = {2'b00, imm_k[5:0]};
         end
         cab_pkg::op_inc, cab_pkg::op_dec: ab.b = cab_pkg::ONE;
         cab_pkg::op_twos_complement_op: begin
            ab.a = cab_pkg::ALL_ZERO;
            ab.b = rf[rd_sel];
         end
         cab_pkg::op_zero_sign_test, cab_pkg::op_register_zeroing: ab.b = rf[rd_sel];
         default: ab.b = rf[rr_sel];
      endcase
   end

   // next state, write enables and pc selection
   always_comb begin
      nxt_st = st_ff;
      cyc = cab_pkg::CYC_1;
      lo_en = 1'b0;
      hi_en = 1'b0;
      lo_idx = rd_sel;
      hi_idx = rd_hi;
      push = 1'b0;
      // bus writes to flags and pc
      fl_base = (reg_wr && reg_addr == cab_pkg::ADR_FLAGS) ? reg_wdata : st_ff.flags;
      nxt_st.flags = fl_base;
      if (reg_wr && reg_addr == cab_pkg::ADR_PC_LO) begin
         nxt_st.pc = {st_ff.pc[PC_W-1:8], reg_wdata};
      end else if (reg_wr && reg_addr == cab_pkg::ADR_PC_HI) begin
         nxt_st.pc = pcw[PC_W-1:0];
      end
      // bus read, answered next cycle
      if (reg_rd) begin
         if (reg_addr <= cab_pkg::ADR_GPR_LAST) begin
            nxt_st.rdata = rf[reg_addr[4:0]];
         end else if (reg_addr == cab_pkg::ADR_FLAGS) begin
            nxt_st.rdata = st_ff.flags;
         end else if (reg_addr == cab_pkg::ADR_PC_LO) begin
            nxt_st.rdata = pc16[7:0];
         end else if (reg_addr == cab_pkg::ADR_PC_HI) begin
            nxt_st.rdata = pc16[15:8];
         end else if (reg_addr == cab_pkg::ADR_DEPTH) begin
            nxt_st.rdata = 8'(st_ff.sp);
         end else begin
            nxt_st.rdata = 8'h00;
         end
      end
      case (st_ff.fsm)
         st_idle: begin
            if (take) begin
               // only flags named by the alu mask change, plus I on an interrupt exit
               nxt_st.flags = (fl_base & ~ab.fmask) | (ab.fval & ab.fmask);
               nxt_st.pc = pc_next;
               case (op_code)
                  cab_pkg::op_word_immediate_increase, cab_pkg::op_word_immediate_decrease: begin
                     lo_en = 1'b1;
                     hi_en = 1'b1;
                     cyc = cab_pkg::CYC_2;
                  end
                  cab_pkg::op_product_unsigned, cab_pkg::op_product_signed,
                  cab_pkg::op_product_mixed_sign, cab_pkg::op_fraction_product_unsigned,
                  cab_pkg::op_fraction_product_signed, cab_pkg::op_fraction_product_mixed: begin
                     lo_en = 1'b1;
                     hi_en = 1'b1;
                     lo_idx = cab_pkg::IDX_PLO;
                     hi_idx = cab_pkg::IDX_PHI;
                     cyc = cab_pkg::CYC_2;
                  end
                  cab_pkg::op_flag_only_difference, cab_pkg::op_flag_only_difference_borrow,
                  cab_pkg::op_flag_only_difference_immediate: lo_en = 1'b0;
                  cab_pkg::op_relative_branch_always: begin
                     nxt_st.pc = st_ff.pc + rel_k + 1'b1;
                     cyc = cab_pkg::CYC_2;
                  end
                  cab_pkg::op_pointer_branch: begin
                     nxt_st.pc = zw[PC_W-1:0];
                     cyc = cab_pkg::CYC_2;
                  end
                  cab_pkg::op_relative_subroutine_entry: begin
                     push = 1'b1;
                     nxt_st.sp = st_ff.sp + 1'b1;
                     nxt_st.pc = st_ff.pc + rel_k + 1'b1;
                     cyc = cab_pkg::CYC_3;
                  end
                  cab_pkg::op_pointer_subroutine_entry: begin
                     push = 1'b1;
                     nxt_st.sp = st_ff.sp + 1'b1;
                     nxt_st.pc = zw[PC_W-1:0];
                     cyc = cab_pkg::CYC_3;
                  end
                  cab_pkg::op_subroutine_exit: begin
                     nxt_st.sp = sp_top;
                     nxt_st.pc = stk[sp_top];
                     cyc = cab_pkg::CYC_4;
                  end
                  cab_pkg::op_interrupt_exit: begin
                     nxt_st.sp = sp_top;
                     nxt_st.pc = stk[sp_top];
                     nxt_st.flags[cab_pkg::FLG_I] = 1'b1;
                     cyc = cab_pkg::CYC_4;
                  end
                  cab_pkg::op_equal_skip: begin
                     if (rf[rd_sel] == rf[rr_sel]) begin
                        if (skip_long) begin
                           nxt_st.pc = st_ff.pc + cab_pkg::SKIP_LONG;
                           cyc = cab_pkg::CYC_3;
                        end else begin
                           nxt_st.pc = st_ff.pc + cab_pkg::SKIP_SHORT;
                           cyc = cab_pkg::CYC_2;
                        end
                     end
                  end
                  // byte results go back to the destination
                  default: lo_en = 1'b1;
               endcase
               // long instructions hold issue
               if (cyc != cab_pkg::CYC_1) begin
                  nxt_st.fsm = st_hold;
                  nxt_st.hold = cyc - 3'h1;
               end
            end
         end
         st_hold: begin
            // count down the remaining cycles
            nxt_st.hold = st_ff.hold - 3'h1;
            if (st_ff.hold == 3'h1) begin
               nxt_st.fsm = st_idle;
            end
         end
         default: begin
            nxt_st.fsm = st_idle;
            nxt_st.hold = 3'h0;
         end
      endcase
   end

   // state register
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         st_ff.fsm <= st_idle;
         st_ff.hold <= 3'h0;
         st_ff.pc <= '0;
         st_ff.sp <= '0;
         st_ff.flags <= cab_pkg::FLAGS_RST;
         st_ff.rdata <= 8'h00;
      end else begin
         st_ff <= nxt_st;
      end
   end

   // register file: alu results win over bus writes
   always_ff @(posedge clk) begin
      if (reg_wr && reg_addr <= cab_pkg::ADR_GPR_LAST) begin
         rf[reg_addr[4:0]] <= reg_wdata;
      end
      if (lo_en) begin
         rf[lo_idx] <= ab.res[7:0];
      end
      if (hi_en) begin
         rf[hi_idx] <= ab.res[15:8];
      end
   end

   // return stack, wraps when full
   always_ff @(posedge clk) begin
      if (push) begin
         stk[st_ff.sp] <= pc_next;
      end
   end
endmodule

// ---- testbench/cab_datapath_asserts.sv ----
// port checker for the alu and branch datapath
`timescale 1ns/1ps
module cab_datapath_asserts #(
   parameter int PC_W = 12,
   parameter int DEPTH = 16
) (
   // clock and reset
   input logic clk,
   input logic rst,
   // instruction port
   input logic op_valid,
   input cab_pkg::cab_op_type op_code,
   input logic [PC_W-1:0] rel_k,
   input logic op_ready,
   // visible state and bus
   input logic [PC_W-1:0] pc_out,
   input logic [7:0] flags_out,
   input logic reg_wr
);
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   // instruction taken at this edge
   logic tk;
   assign tk = op_valid && op_ready;
   a_add_single: assert property (tk && op_code == cab_pkg::op_add |=> op_ready) else $error("add stalled");
   a_word_two: assert property (tk && op_code inside {cab_pkg::op_word_immediate_increase,
      cab_pkg::op_word_immediate_decrease} |=> !op_ready ##1 op_ready) else $error("word op timing");
   a_prod_two: assert property (tk && op_code inside {[cab_pkg::op_product_unsigned:cab_pkg::op_fraction_product_mixed]}
      |=> !op_ready ##1 op_ready) else $error("product timing");
   a_call_three: assert property (tk && op_code inside {cab_pkg::op_relative_subroutine_entry,
      cab_pkg::op_pointer_subroutine_entry} |=> !op_ready [*2] ##1 op_ready) else $error("call timing");
   a_exit_four: assert property (tk && op_code inside {cab_pkg::op_subroutine_exit, cab_pkg::op_interrupt_exit}
      |=> !op_ready [*3] ##1 op_ready) else $error("return timing");
   a_jump_target: assert property (tk && op_code == cab_pkg::op_relative_branch_always
      |=> pc_out == PC_W'($past(pc_out) + $past(rel_k) + 1)) else $error("jump target wrong");
   a_inc_carry: assert property (tk && op_code inside {cab_pkg::op_inc, cab_pkg::op_dec} && !reg_wr
      |=> flags_out[0] == $past(flags_out[0])) else $error("carry changed");
   a_ones_flags: assert property (tk && op_code == cab_pkg::op_register_all_ones && !reg_wr
      |=> $stable(flags_out)) else $error("all ones moved flags");
   a_skip_flags: assert property (tk && op_code == cab_pkg::op_equal_skip && !reg_wr
      |=> $stable(flags_out)) else $error("skip moved flags");
   a_exit_ie: assert property (tk && op_code == cab_pkg::op_interrupt_exit |=> flags_out[7]) else $error("ie not set");
endmodule
bind cab_datapath cab_datapath_asserts #(.PC_W(PC_W), .DEPTH(DEPTH)) cab_datapath_asserts_inst (.clk(clk), .rst(rst),
   .op_valid(op_valid), .op_code(op_code), .rel_k(rel_k), .op_ready(op_ready), .pc_out(pc_out),
   .flags_out(flags_out), .reg_wr(reg_wr));

// ---- testbench/cab_fetch_model.sv ----
// fetch and decode stand-in offering one instruction at a time
`timescale 1ns/1ps
module cab_fetch_model (
   // clock and reset
   input logic clk,
   input logic rst,
   // request from bench: {code, rd, rr, k, rel, long}
   input logic st,
   input logic [36:0] ins,
   // instruction port
   input logic op_ready,
   output logic op_valid = 1'b0,
   output cab_pkg::cab_op_type op_code = cab_pkg::op_add,
   output logic [4:0] rd_sel = 5'h00,
   output logic [4:0] rr_sel = 5'h00,
   output logic [7:0] imm_k = 8'h00,
   output logic [11:0] rel_k = 12'h000,
   output logic skip_long = 1'b0,
   // taken pulse
   output logic done = 1'b0
);
   // hold the offer until taken, then invert every field but the code so stale operands never pass
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         op_valid <= 1'b0;
         done <= 1'b0;
      end else if (op_valid && op_ready) begin
         op_valid <= 1'b0;
         done <= 1'b1;
         {rd_sel, rr_sel, imm_k, rel_k, skip_long} <= ~{rd_sel, rr_sel, imm_k, rel_k, skip_long};
      end else begin
         done <= 1'b0;
         if (st && !op_valid) begin
            op_valid <= 1'b1;
            op_code <= cab_pkg::cab_op_type'(ins[36:31]);
            {rd_sel, rr_sel, imm_k, rel_k, skip_long} <= ins[30:0];
         end
      end
   end
endmodule

// ---- testbench/cab_datapath_tb.sv ----
// self-checking bench for the alu and branch datapath
`timescale 1ns/1ps
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin n_fail++; \
   $display("mismatch t=%0t got=%h exp=%h", $time, g, e); end end
module cab_datapath_tb;
   logic clk = 1'b0, rst = 1'b1, st = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, pend = 1'b0;
   logic [36:0] ins = '0;
   logic [5:0] reg_addr = 6'h00;
   logic [7:0] reg_wdata = 8'h00, reg_rdata, flags_out, a, b, c, x, fl, ev, exq[$];
   logic [11:0] pc_out, rel_k;
   logic [4:0] rd_sel, rr_sel;
   logic [7:0] imm_k;
   logic [13:0] e;
   logic [15:0] p, q, w;
   logic op_valid, op_ready, skip_long, done;
   logic [31:0] sd = 32'h000015b7;
   cab_pkg::cab_op_type op_code;
   int n_fail = 0, num_checks = 0;
   cab_pkg::cab_op_type aops[9] = '{cab_pkg::op_add, cab_pkg::op_adc, cab_pkg::op_sub,
      cab_pkg::op_difference_with_borrow, cab_pkg::op_difference_immediate, cab_pkg::op_difference_immediate_borrow,
      cab_pkg::op_flag_only_difference, cab_pkg::op_flag_only_difference_borrow,
      cab_pkg::op_flag_only_difference_immediate};
   cab_datapath #(.PC_W(12), .DEPTH(16)) cab_datapath_inst (.clk(clk), .rst(rst), .op_valid(op_valid),
      .op_code(op_code), .rd_sel(rd_sel), .rr_sel(rr_sel), .imm_k(imm_k), .rel_k(rel_k), .skip_long(skip_long),
      .op_ready(op_ready), .pc_out(pc_out), .flags_out(flags_out), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
   cab_fetch_model cab_fetch_model_inst (.clk(clk), .rst(rst), .st(st), .ins(ins), .op_ready(op_ready),
      .op_valid(op_valid), .op_code(op_code), .rd_sel(rd_sel), .rr_sel(rr_sel), .imm_k(imm_k), .rel_k(rel_k),
      .skip_long(skip_long), .done(done));
   always #5 clk = ~clk;
   // xorshift source
   function automatic logic [7:0] xs();
      sd ^= sd << 13;
      sd ^= sd >> 17;
      sd ^= sd << 5;
      return sd[7:0];
   endfunction
   // expected byte add or subtract: {result, h, s, v, n, z, c}
   function automatic logic [13:0] ar(input logic [7:0] a, b, input logic c, s);
      logic [8:0] r;
      logic [4:0] h;
      logic v;
      r = s ? {1'b0, a} - b - c : {1'b0, a} + b + c;
      h = s ? {1'b0, a[3:0]} - b[3:0] - c : {1'b0, a[3:0]} + b[3:0] + c;
      v = s ? (a[7] ^ b[7]) & (a[7] ^ r[7]) : ~(a[7] ^ b[7]) & (a[7] ^ r[7]);
      return {r[7:0], h[4], r[7] ^ v, v, r[7], r[7:0] == 8'h00, r[8]};
   endfunction
   // bus write
   task automatic wr(input logic [5:0] ad, input logic [7:0] d);
      @(posedge clk);
      reg_wr <= 1'b1;
      reg_addr <= ad;
      reg_wdata <= d;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask
   // bus read, expectation queued for the monitor
   task automatic rd(input logic [5:0] ad, input logic [7:0] ex);
      @(posedge clk);
      reg_rd <= 1'b1;
      reg_addr <= ad;
      exq.push_back(ex);
      @(posedge clk);
      reg_rd <= 1'b0;
   endtask
   // one instruction through the fetch model, bounded wait for its take
   task automatic op(input cab_pkg::cab_op_type oc, input logic [4:0] d = 16, r = 17,
      input logic [7:0] k = 0, input logic [11:0] j = 0, input logic l = 0);
      @(posedge clk);
      st <= 1'b1;
      ins <= {oc, d, r, k, j, l};
      @(posedge clk);
      st <= 1'b0;
      repeat (20) if (!done) @(posedge clk);
      if (!done) n_fail++;
   endtask
   // read data checked the cycle after each read strobe
   always @(posedge clk) begin
      if (pend) begin
         ev = exq.pop_front();
         `CHK(reg_rdata, ev)
      end
      pend <= reg_rd;
   end
   task automatic tally_and_finish();
      repeat (3) @(posedge clk);
      $display("checks %0d mismatches %0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   initial begin
      #100000;
      n_fail++;
      tally_and_finish();
   end
   initial begin
      repeat (8) @(posedge clk);
      rst <= 1'b0;
      rd(cab_pkg::ADR_FLAGS, 8'h00);
      wr(6'h24, 8'h5a);
      rd(6'h24, 8'h00);
      $display("reset and map done");
      foreach (aops[i]) begin
         a = xs();
         b = xs();
         c = xs();
         wr(cab_pkg::ADR_FLAGS, {7'h00, c[0]});
         wr(6'd16, a);
         wr(6'd17, b);
         op(aops[i], 16, 17, b);
         e = ar(a, b, c[0] & (i % 2 == 1), i > 1);
         rd(6'd16, i < 6 ? e[13:6] : a);
         rd(cab_pkg::ADR_FLAGS, {2'b00, e[5:0]});
      end
      $display("arith done");
      for (int f = 0; f < 2; f++) begin
         a = xs();
         b = xs();
         wr(cab_pkg::ADR_FLAGS, 8'h00);
         wr(6'd16, a);
         wr(6'd17, b);
         op(f ? cab_pkg::op_fraction_product_unsigned : cab_pkg::op_product_unsigned);
         p = a * b;
         q = f ? p << 1 : p;
         rd(6'd0, q[7:0]);
         rd(6'd1, q[15:8]);
         rd(cab_pkg::ADR_FLAGS, {6'h00, q == 16'h0000, p[15]});
      end
      a = xs();
      b = xs();
      c = xs() & 8'h3f;
      wr(6'd24, a);
      wr(6'd25, b);
      op(cab_pkg::op_word_immediate_increase, 24, 17, c);
      w = {b, a} + c;
      rd(6'd24, w[7:0]);
      rd(6'd25, w[15:8]);
      $display("products and word done");
      // increment keeps carry, all ones keeps flags
      wr(cab_pkg::ADR_FLAGS, 8'h01);
      wr(6'd2, a);
      op(cab_pkg::op_inc, 2);
      op(cab_pkg::op_register_all_ones, 3);
      x = a + 8'h01;
      fl = {3'b000, x[7] ^ (x == 8'h80), x == 8'h80, x[7], x == 8'h00, 1'b1};
      rd(6'd2, x);
      rd(6'd3, 8'hff);
      rd(cab_pkg::ADR_FLAGS, fl);
      wr(cab_pkg::ADR_PC_LO, 8'h10);
      wr(cab_pkg::ADR_PC_HI, 8'h00);
      op(cab_pkg::op_relative_subroutine_entry, 16, 17, 0, 12'h005);
      rd(cab_pkg::ADR_PC_LO, 8'h16);
      op(cab_pkg::op_subroutine_exit);
      rd(cab_pkg::ADR_PC_LO, 8'h11);
      op(cab_pkg::op_relative_branch_always, 16, 17, 0, 12'hffe);
      rd(cab_pkg::ADR_PC_LO, 8'h10);
      op(cab_pkg::op_equal_skip, 2, 2, 0, 0, 1);
      rd(cab_pkg::ADR_PC_LO, 8'h13);
      op(cab_pkg::op_relative_subroutine_entry);
      op(cab_pkg::op_interrupt_exit);
      rd(cab_pkg::ADR_PC_LO, 8'h14);
      rd(cab_pkg::ADR_FLAGS, fl | 8'h80);
      wr(6'd30, 8'h2a);
      wr(6'd31, 8'h00);
      op(cab_pkg::op_pointer_subroutine_entry);
      rd(cab_pkg::ADR_PC_LO, 8'h2a);
      rd(cab_pkg::ADR_DEPTH, 8'h01);
      wr(6'd30, 8'h3c);
      op(cab_pkg::op_pointer_branch);
      rd(cab_pkg::ADR_PC_LO, 8'h3c);
      op(cab_pkg::op_bit_inversion, 3);
      rd(6'd3, 8'h00);
      rd(cab_pkg::ADR_FLAGS, 8'h83);
      $display("branch flow done");
      tally_and_finish();
   end
endmodule
